/* File: common/floppy_result_map.vh */
// Register offsets, field positions and codes of the floppy result and status bank
`ifndef FLOPPY_RESULT_MAP_VH
`define FLOPPY_RESULT_MAP_VH

// Register offsets (one byte each on the plain port)
`define RES_ADDR_COMPLETION   3'h0
`define RES_ADDR_TERMINATION  3'h1
`define RES_ADDR_XFER_ERR     3'h2
`define RES_ADDR_FIELD_ERR    3'h3
`define RES_ADDR_DRIVE_LINE   3'h4
`define RES_ADDR_EVENT_CLEAR  3'h5

// Completion codes of the first result byte
`define CC_NO_ERROR     8'h00
`define CC_GENERAL      8'h01
`define CC_UNSUPPORTED  8'h02
`define CC_ABSENT       8'h03
`define CC_INVALID_CMD  8'h04
`define CC_IRQ_DMA      8'h05
`define CC_CTRL_ERROR   8'h06
`define CC_IN_PROGRESS  8'hFF

// Termination code values
`define TC_NORMAL    2'h0
`define TC_ABNORMAL  2'h1
`define TC_INVALID   2'h2
`define TC_READY_CHG 2'h3

// Termination status fields
`define TS_TC_HI      7
`define TS_TC_LO      6
`define TS_POS_DONE   5
`define TS_FAULT      4
`define TS_NOT_READY  3
`define TS_HEAD       2
`define TS_SEL1       1
`define TS_SEL0       0

// Transfer error status fields
`define XE_PAST_END   7
`define XE_CRC_ANY    5
`define XE_OVERRUN    4
`define XE_SECT_MISS  2
`define XE_WP_HIT     1
`define XE_ID_SYNC    0

// Field error status fields
`define FE_DELETED    6
`define FE_DATA_CRC   5
`define FE_WRONG_TRK  4
`define FE_SCAN_EQ    3
`define FE_SCAN_NONE  2
`define FE_BAD_TRK    1
`define FE_DATA_MARK  0

// Recalibrate step limit and the bad-track cylinder value
`define RECAL_STEPS   7'd77
`define BAD_CYL_VALUE 8'hFF

// Event vector bit positions
`define EV_SEEK_DONE    0
`define EV_DRIVE_FAULT  1
`define EV_PAST_END     2
`define EV_CRC_ID       3
`define EV_CRC_DATA     4
`define EV_OVERRUN      5
`define EV_SECT_MISS    6
`define EV_READID_FAIL  7
`define EV_START_MISS   8
`define EV_NO_DATA_MARK 9
`define EV_NO_ID_MARK   10
`define EV_DELETED      11
`define EV_SCAN_EQ      12
`define EV_SCAN_NONE    13
`define EV_COUNT        14

`endif

/* File: tb/floppy_drive_model.sv */
// Floppy drive status lines as seen by the controller
`timescale 1ns/1ps
`default_nettype none
module floppy_drive_model (
  // Clock
  input  wire logic       core_clk,
  // Requested drive state: fault, protect, ready, track zero, two side
  input  wire logic [4:0] lines,
  // Lines to the controller
  output var  logic       drive_fault_line,
  output var  logic       write_protect_line,
  output var  logic       drive_ready_line,
  output var  logic       track_zero_line,
  output var  logic       double_sided_line
);
  // Lines settle one cycle after a state change, like a real drive
  always @(posedge core_clk)
    {drive_fault_line, write_protect_line, drive_ready_line, track_zero_line, double_sided_line} <= lines;
endmodule // floppy_drive_model
`default_nettype wire

/* File: tb/floppy_result_status_monitor.sv */
// Port-level concurrent checks of the floppy result and status bank
`timescale 1ns/1ps
`default_nettype none
`include "floppy_result_map.vh"
module floppy_result_status_monitor #(
  parameter STEP_LIMIT = 7
) (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       srst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Command and drive side
  input wire logic       cmd_start,
  input wire logic       cmd_done,
  input wire logic       cmd_is_recal,
  input wire logic       step_pulse,
  input wire logic       drive_fault_line,
  input wire logic       write_protect_line,
  input wire logic       drive_ready_line,
  input wire logic       track_zero_line,
  input wire logic       double_sided_line,
  input wire logic       head_side,
  input wire logic       drive_select_bit1,
  input wire logic       drive_select_bit0,
  // Status outputs
  input wire logic       recal_fail,
  input wire logic       cmd_running
);
  logic [6:0] steps_q;
  wire  [7:0] lines = {drive_fault_line, write_protect_line, drive_ready_line, track_zero_line,
                       double_sided_line, head_side, drive_select_bit1, drive_select_bit0};
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Saturating, so a stuck stepper cannot wrap back under the limit
  always @(posedge core_clk)
    if (srst || cmd_start) steps_q <= 7'h00;
    else if (step_pulse && cmd_is_recal && steps_q != 7'h7F) steps_q <= steps_q + 7'h01;
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside answer cycle");
  a_xfer_unused: assert property ($past(reg_rd) && $past(reg_addr) == `RES_ADDR_XFER_ERR |-> reg_rdata[6] == 1'b0 && reg_rdata[3] == 1'b0)
    else $error("unused transfer bits set");
  a_field_unused: assert property ($past(reg_rd) && $past(reg_addr) == `RES_ADDR_FIELD_ERR |-> reg_rdata[7] == 1'b0)
    else $error("unused field bit set");
  a_drive_mirror: assert property ($past(reg_rd) && $past(reg_addr) == `RES_ADDR_DRIVE_LINE |-> reg_rdata == $past(lines))
    else $error("drive line byte differs from lines");
  a_busy_code: assert property ($past(reg_rd) && $past(reg_addr) == `RES_ADDR_COMPLETION && $past(cmd_running) |-> reg_rdata == `CC_IN_PROGRESS)
    else $error("running command not reported in progress");
  a_run_set: assert property (cmd_start && !cmd_done |=> cmd_running)
    else $error("command start not taken");
  a_run_clear: assert property (cmd_running && cmd_done && !cmd_start |=> !cmd_running)
    else $error("command done not taken");
  a_recal_clear: assert property (cmd_start |=> !recal_fail)
    else $error("recalibrate failure not cleared at start");
  a_recal_count: assert property ($rose(recal_fail) |-> steps_q >= `RECAL_STEPS)
    else $error("recalibrate failure before step limit");
  c_done: cover property (cmd_running && cmd_done);
  c_recal: cover property ($rose(recal_fail));
  c_lines: cover property (reg_rd && reg_addr == `RES_ADDR_DRIVE_LINE);
endmodule // floppy_result_status_monitor
bind floppy_result_status floppy_result_status_monitor #(.STEP_LIMIT(STEP_LIMIT)) u_mon (.*);
`default_nettype wire

/* File: tb/floppy_result_status_test.sv */
// Self-checking testbench of the floppy result and status bank
`timescale 1ns/1ps
`default_nettype none
`include "floppy_result_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module floppy_result_status_test;
  logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, cmd_start = 0, cmd_done = 0, cmd_invalid = 0;
  logic cmd_is_rw = 0, cmd_is_write = 0, cmd_is_scan = 0, cmd_is_recal = 0, step_pulse = 0, id_check = 0;
  logic head_side = 0, drive_select_bit1 = 0, drive_select_bit0 = 0;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, cmd_completion = 0, medium_cyl = 0, sector_id_cyl = 0, d, t, x, f, c, r = 8'h5D;
  logic [`EV_COUNT-1:0] cmd_event = 0;
  logic [4:0] lines = 5'h04;
  logic [23:0] m;
  wire [7:0] reg_rdata;
  wire drive_fault_line, write_protect_line, drive_ready_line, track_zero_line, double_sided_line;
  wire recal_fail, cmd_running;
  int num_errors = 0, cmp_count = 0;
  always #10 core_clk = ~core_clk;
  floppy_result_status #(.STEP_LIMIT(7)) dut (.*);
  floppy_drive_model drv (.core_clk(core_clk), .lines(lines), .drive_fault_line(drive_fault_line),
    .write_protect_line(write_protect_line), .drive_ready_line(drive_ready_line),
    .track_zero_line(track_zero_line), .double_sided_line(double_sided_line));
  function automatic logic [7:0] nx(input logic [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Bits expected per scenario: termination, transfer error, field error
  function automatic logic [23:0] em(input int i);
    case (i)
      0: em = 24'h200000;   1: em = 24'h100000;   2: em = 24'h008000;   3: em = 24'h002000;
      4: em = 24'h002020;   5: em = 24'h001000;   9: em = 24'h000101;   10: em = 24'h000100;
      11: em = 24'h000040;  12: em = 24'h000008;  13: em = 24'h000004;  14: em = 24'h000010;
      15: em = 24'h000012;  16: em = 24'h080000;  17: em = 24'h000200;  18: em = 24'h800000;
      19: em = 24'h100000;  default: em = 24'h000400;
    endcase
  endfunction
  task automatic tick;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_rd <= 1; reg_addr <= a; tick; reg_rd <= 0; #1 v = reg_rdata; tick;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_wr <= 1; reg_addr <= a; reg_wdata <= v; tick; reg_wr <= 0; tick;
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #200000; num_errors++; final_report;
  end
  initial begin
    repeat (6) tick; srst <= 0; tick;
    cmd_completion <= 8'h05; cmd_done <= 1; tick; cmd_done <= 0;
    for (int a = 0; a < 4; a++) begin rd(a[2:0], d); `CHK(d, 8'h00) end
    for (int a = 5; a < 8; a++) begin rd(a[2:0], d); `CHK(d, 8'h00) end
    $display("reset and unmapped reads done");
    for (int i = 0; i < 20; i++)
    begin
      r = nx(r); m = em(i); c = (i % 8 == 7) ? `CC_IN_PROGRESS : 8'(i % 8);
      lines <= (i == 16) ? 5'h00 : (i == 17) ? 5'h0C : 5'h04;
      cmd_is_scan <= (i == 12 || i == 13); cmd_is_rw <= (i == 16); cmd_is_write <= (i == 17);
      cmd_is_recal <= (i == 19); cmd_invalid <= (i == 18); cmd_completion <= c;
      {head_side, drive_select_bit1, drive_select_bit0} <= r[2:0];
      medium_cyl <= (i == 15) ? 8'hFF : {1'b0, r[6:0]}; sector_id_cyl <= {1'b0, ~r[6:0]};
      repeat (2) tick; cmd_start <= 1; tick; cmd_start <= 0;
      rd(`RES_ADDR_COMPLETION, d); `CHK(d, `CC_IN_PROGRESS)
      if (i < 14) begin cmd_event <= 14'h1 << i; tick; cmd_event <= 0; end
      if (i == 14 || i == 15) begin id_check <= 1; tick; id_check <= 0; end
      if (i == 19)
      begin
        repeat (76) begin step_pulse <= 1; tick; step_pulse <= 0; tick; end
        `CHK(recal_fail, 1'b0)
        step_pulse <= 1; tick; step_pulse <= 0; tick; #1;
        `CHK(recal_fail, 1'b1)
      end
      tick; cmd_done <= 1; tick; cmd_done <= 0;
      rd(`RES_ADDR_COMPLETION, d); `CHK(d, c)
      rd(`RES_ADDR_TERMINATION, t); rd(`RES_ADDR_XFER_ERR, x); rd(`RES_ADDR_FIELD_ERR, f);
      `CHK(t[2:0], r[2:0])
      `CHK({t, x, f} & m, m)
      if (i == 6) `CHK(t[7:6], `TC_ABNORMAL)
      if (i == 18) `CHK(t[7:6], `TC_INVALID)
      if (i == 14) `CHK(f[1], 1'b0)
      wr(`RES_ADDR_TERMINATION, r); rd(`RES_ADDR_TERMINATION, d); `CHK(d, t)
      $display("command scenario %0d done", i);
    end
    for (int k = 0; k < 8; k++)
    begin
      r = nx(r); lines <= r[7:3]; {head_side, drive_select_bit1, drive_select_bit0} <= r[2:0];
      repeat (2) tick; rd(`RES_ADDR_DRIVE_LINE, d); `CHK(d, r)
    end
    $display("drive line scenario done");
    final_report;
  end
endmodule // floppy_result_status_test
`default_nettype wire

/* File: verilog/floppy_result_status.v */
// Result and status reporting bank of a floppy disk controller
`timescale 1ns/1ps
`default_nettype none
`include "floppy_result_map.vh"
// How it works
// - First byte carries the completion code
// - Bytes two to five carry status registers
// - Bits 7:6 hold the termination code
// - Bit 5 marks seek finished
// - Bit 4 flags drive fault or recalibrate timeout
// - Bit 3 flags not ready or missing side
// - Low bits capture side and unit select
// - Transfer bit 7 flags past last sector
// - Unused bits always read zero
// - Transfer bit 5 flags any CRC fault
// - Transfer bit 4 flags service overrun
// - Transfer bit 2 flags sector missing
// - Transfer bit 1 flags write protect hit
// - Transfer bit 0 flags missing address mark
// - Field bit 6 flags deleted data mark
// - Field bit 5 flags data field CRC
// - Field bits 4 and 1 flag cylinder mismatch
// - Field bits 3 and 2 report scan outcome
// - Field bit 0 flags missing data mark
// - Drive line bits 7:3 mirror drive inputs
// - Drive line bits 2:0 mirror select outputs

module floppy_result_status #(
  parameter STEP_LIMIT = 7
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       srst,
  // Register port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Command sequencer
  input  wire       cmd_start,
  input  wire       cmd_done,
  input  wire [7:0] cmd_completion,
  input  wire       cmd_invalid,
  input  wire       cmd_is_rw,
  input  wire       cmd_is_write,
  input  wire       cmd_is_scan,
  input  wire       cmd_is_recal,
  input  wire       step_pulse,
  input  wire [`EV_COUNT-1:0] cmd_event,
  input  wire       id_check,
  input  wire [7:0] medium_cyl,
  input  wire [7:0] sector_id_cyl,
  // Drive lines
  input  wire       drive_fault_line,
  input  wire       write_protect_line,
  input  wire       drive_ready_line,
  input  wire       track_zero_line,
  input  wire       double_sided_line,
  input  wire       head_side,
  input  wire       drive_select_bit1,
  input  wire       drive_select_bit0,
  // Outputs
  output wire       recal_fail,
  output reg        cmd_running
);

  // ------------------------------------------------------------
  // Accumulation of events during a command
  // ------------------------------------------------------------
  reg [`EV_COUNT-1:0] ev_q;
  reg                 wp_hit_q;
  reg                 not_ready_q;
  reg                 ready_chg_q;
  reg                 ready_ref_q;
  reg                 wrong_trk_q;
  reg                 bad_trk_q;
  reg [6:0]           step_cnt_q;
  reg                 recal_fail_q;
  reg                 ev_clear_q;

  // Writes to the spare offset only leave a one-cycle readback trace
  wire       sw_clear      = reg_wr && (reg_addr == `RES_ADDR_EVENT_CLEAR);
  wire [6:0] step_limit_w  = `RECAL_STEPS;
  wire       step_seen     = cmd_running && cmd_is_recal && step_pulse && !track_zero_line;
  wire       recal_timeout = step_seen && (step_cnt_q == step_limit_w - 7'd1);
  wire       cyl_differs   = id_check && (medium_cyl != sector_id_cyl);
  wire       bad_cyl_seen  = cyl_differs && (medium_cyl == `BAD_CYL_VALUE);
  wire       wp_seen       = cmd_is_write && write_protect_line;
  wire       side_missing  = head_side && !double_sided_line;

  assign recal_fail = recal_fail_q;

  // ------------------------------------------------------------
  // Command running flag
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (srst)
      cmd_running <= 1'b0;
    else if (cmd_start)
      cmd_running <= 1'b1;
    else if (cmd_done)
      cmd_running <= 1'b0;
  end

  // ------------------------------------------------------------
  // Event set: restarted by a command start, then set only
  // ------------------------------------------------------------
  // A pulse on the start edge itself is kept, so no event is lost
  always @(posedge core_clk)
  begin
    if (srst)
      ev_q <= {`EV_COUNT{1'b0}};
    else if (cmd_start)
      ev_q <= cmd_event;
    else if (cmd_running)
      ev_q <= ev_q | cmd_event;
  end

  // ------------------------------------------------------------
  // Write protect hit during a write command
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (srst)
      wp_hit_q <= 1'b0;
    else if (cmd_start)
      wp_hit_q <= wp_seen;
    else if (cmd_running && wp_seen)
      wp_hit_q <= 1'b1;
  end

  // ------------------------------------------------------------
  // Not ready, judged once at the start of a read or write
  // ------------------------------------------------------------
  // A drive that drops ready later is reported by the ready change code
  always @(posedge core_clk)
  begin
    if (srst)
      not_ready_q <= 1'b0;
    else if (cmd_start)
      not_ready_q <= cmd_is_rw && (!drive_ready_line || side_missing);
  end

  // ------------------------------------------------------------
  // Ready line change during execution
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      ready_ref_q <= 1'b0;
      ready_chg_q <= 1'b0;
    end
    else if (cmd_start)
    begin
      ready_ref_q <= drive_ready_line;
      ready_chg_q <= 1'b0;
    end
    else if (cmd_running && (drive_ready_line != ready_ref_q))
      ready_chg_q <= 1'b1;
  end

  // ------------------------------------------------------------
  // Cylinder checks of the sector ID against the medium
  // ------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (srst || cmd_start)
    begin
      wrong_trk_q <= 1'b0;
      bad_trk_q   <= 1'b0;
    end
    else if (cmd_running)
    begin
      if (cyl_differs)
        wrong_trk_q <= 1'b1;
      if (bad_cyl_seen)
        bad_trk_q <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Recalibrate step count and timeout
  // ------------------------------------------------------------
  // Steps taken on track zero are not counted: the head has arrived
  always @(posedge core_clk)
  begin
    if (srst || cmd_start)
      step_cnt_q <= 7'd0;
    else if (step_seen)
      step_cnt_q <= step_cnt_q + 7'd1;
  end

  always @(posedge core_clk)
  begin
    if (srst || cmd_start)
      recal_fail_q <= 1'b0;
    else if (recal_timeout)
      recal_fail_q <= 1'b1;
  end

  // Readback trace of the spare offset
  always @(posedge core_clk)
  begin
    if (srst)
      ev_clear_q <= 1'b0;
    else
      ev_clear_q <= sw_clear;
  end

  // ------------------------------------------------------------
  // Status images assembled from the events
  // ------------------------------------------------------------
  // Priority: invalid, then ready change, then any error flag
  function [1:0] term_code;
    input invalid;
    input ready_changed;
    input any_error;
    begin
      if (invalid)
        term_code = `TC_INVALID;
      else if (ready_changed)
        term_code = `TC_READY_CHG;
      else if (any_error)
        term_code = `TC_ABNORMAL;
      else
        term_code = `TC_NORMAL;
    end
  endfunction

  wire       any_error_w = |ev_q[`EV_NO_ID_MARK:`EV_PAST_END] || not_ready_q || wp_hit_q
                           || recal_fail_q || wrong_trk_q || ev_q[`EV_DRIVE_FAULT];
  wire [1:0] tc_w        = term_code(cmd_invalid, ready_chg_q, any_error_w);

  wire [7:0] term_w;
  assign term_w[`TS_TC_HI:`TS_TC_LO] = tc_w;
  assign term_w[`TS_POS_DONE]  = ev_q[`EV_SEEK_DONE];
  assign term_w[`TS_FAULT]     = ev_q[`EV_DRIVE_FAULT] | drive_fault_line | recal_fail_q;
  assign term_w[`TS_NOT_READY] = not_ready_q;
  assign term_w[`TS_HEAD]      = head_side;
  assign term_w[`TS_SEL1]      = drive_select_bit1;
  assign term_w[`TS_SEL0]      = drive_select_bit0;

  wire [7:0] xfer_w;
  assign xfer_w[`XE_PAST_END]  = ev_q[`EV_PAST_END];
  assign xfer_w[6]             = 1'b0;
  assign xfer_w[`XE_CRC_ANY]   = ev_q[`EV_CRC_ID] | ev_q[`EV_CRC_DATA];
  assign xfer_w[`XE_OVERRUN]   = ev_q[`EV_OVERRUN];
  assign xfer_w[3]             = 1'b0;
  assign xfer_w[`XE_SECT_MISS] = ev_q[`EV_SECT_MISS] | ev_q[`EV_READID_FAIL]
                                 | ev_q[`EV_START_MISS] | wrong_trk_q;
  assign xfer_w[`XE_WP_HIT]    = wp_hit_q;
  assign xfer_w[`XE_ID_SYNC]   = ev_q[`EV_NO_DATA_MARK] | ev_q[`EV_NO_ID_MARK];

  wire [7:0] field_w;
  assign field_w[7]             = 1'b0;
  assign field_w[`FE_DELETED]   = ev_q[`EV_DELETED];
  assign field_w[`FE_DATA_CRC]  = ev_q[`EV_CRC_DATA];
  assign field_w[`FE_WRONG_TRK] = wrong_trk_q;
  assign field_w[`FE_SCAN_EQ]   = cmd_is_scan & ev_q[`EV_SCAN_EQ];
  assign field_w[`FE_SCAN_NONE] = cmd_is_scan & ev_q[`EV_SCAN_NONE];
  assign field_w[`FE_BAD_TRK]   = bad_trk_q;
  assign field_w[`FE_DATA_MARK] = ev_q[`EV_NO_DATA_MARK];

  // Live drive lines; not latched so software sees the present state
  wire [7:0] drive_w;
  assign drive_w[7] = drive_fault_line;
  assign drive_w[6] = write_protect_line;
  assign drive_w[5] = drive_ready_line;
  assign drive_w[4] = track_zero_line;
  assign drive_w[3] = double_sided_line;
  assign drive_w[2] = head_side;
  assign drive_w[1] = drive_select_bit1;
  assign drive_w[0] = drive_select_bit0;

  // ------------------------------------------------------------
  // Latched result bytes
  // ------------------------------------------------------------
  reg [7:0] completion_q;
  reg [7:0] termination_status_q;
  reg [7:0] transfer_error_status_q;
  reg [7:0] field_error_status_q;

  // Only a command that really ran may replace the latched bytes
  wire cmd_ends = cmd_running && cmd_done;

  always @(posedge core_clk)
  begin
    if (srst)
      completion_q <= `CC_NO_ERROR;
    else if (cmd_start)
      completion_q <= `CC_IN_PROGRESS;
    else if (cmd_ends)
      completion_q <= cmd_completion;
  end

  // Host writes never reach these; they change only at termination
  always @(posedge core_clk)
  begin
    if (srst)
      termination_status_q <= 8'h00;
    else if (cmd_ends && !cmd_start)
      termination_status_q <= term_w;
  end

  always @(posedge core_clk)
  begin
    if (srst)
      transfer_error_status_q <= 8'h00;
    else if (cmd_ends && !cmd_start)
      transfer_error_status_q <= xfer_w;
  end

  always @(posedge core_clk)
  begin
    if (srst)
      field_error_status_q <= 8'h00;
    else if (cmd_ends && !cmd_start)
      field_error_status_q <= field_w;
  end

  // ------------------------------------------------------------
  // Read port, data valid the cycle after the strobe
  // ------------------------------------------------------------
  // An unmapped index reads zero, so software never sees stale bytes
  function [7:0] read_mux;
    input [2:0] addr;
    input [7:0] completion;
    input [7:0] termination;
    input [7:0] xfer;
    input [7:0] field;
    input [7:0] drive;
    input       clear_trace;
    begin
      case (addr)
        `RES_ADDR_COMPLETION:  read_mux = completion;
        `RES_ADDR_TERMINATION: read_mux = termination;
        `RES_ADDR_XFER_ERR:    read_mux = xfer;
        `RES_ADDR_FIELD_ERR:   read_mux = field;
        `RES_ADDR_DRIVE_LINE:  read_mux = drive;
        `RES_ADDR_EVENT_CLEAR: read_mux = {7'h00, clear_trace};
        default:               read_mux = 8'h00;
      endcase
    end
  endfunction

  // Data stand one cycle only; zero otherwise keeps the bus quiet
  always @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= read_mux(reg_addr, completion_q, termination_status_q, transfer_error_status_q,
                            field_error_status_q, drive_w, ev_clear_q);
    else
      reg_rdata <= 8'h00;
  end

endmodule // floppy_result_status
`default_nettype wire
